// [rtl/mts_selector.sv]
// multi-tariff energy selector with axi4-lite register access
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "mts_regs.svh"

module mts_selector (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [10:0] rtc_min_of_day,
	input  wire logic [3:0]  rtc_month,
	input  wire logic [4:0]  rtc_day,
	input  wire logic [2:0]  rtc_wday,
	input  wire logic        din1,
	input  wire logic        din2,
	input  wire logic        energy_vld,
	input  wire logic [15:0] energy_inc,
	output logic [2:0]       tariff_code,
	output logic [3:0]       tariff_sel
);

	localparam int NT = `MTS_NUM_TAR;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	mts_pkg::mts_bus_e        wst_reg, wst_next, rst_reg, rst_next;
	logic                     awready_next, wready_next, bvalid_next;
	logic [1:0]               bresp_next, rresp_next;
	logic                     arready_next, rvalid_next;
	logic [31:0]              rdata_next;

	logic [31:0]              ctrl_reg, ctrl_next, cmd_reg, cmd_next;
	logic [NT-1:0][31:0]      wt_reg, wt_next, wd_reg, wd_next;
	logic [NT-1:0][31:0]      wc_reg, wc_next;
	logic [NT-1:0]            clr_reg, clr_next;

	logic [10:0]              snap_min_reg, snap_min_next;
	logic [3:0]               snap_mon_reg, snap_mon_next;
	logic [4:0]               snap_day_reg, snap_day_next;
	logic [2:0]               snap_wd_reg, snap_wd_next;
	logic                     snap_ok_reg, snap_ok_next;
	mts_pkg::mts_tar_t        act_reg, act_next;
	logic [NT-1:0]            sel_next;
	logic                     confl_reg, confl_next;

	logic [NT-1:0]            win_valid, win_hit, win_en;
	logic [NT-1:0][31:0]      acc;
	mts_pkg::mts_tar_t        tod_tar, di_tar, cmd_tar;
	logic [2:0]               hit_cnt;
	logic                     wr_ok, rd_ok;
	logic [3:0]               wpage, rpage;
	logic [1:0]               wword, rword, widx, ridx;

	// ----------------------------------------------------------------
	// byte-lane merge for partial writes
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				res[b*8 +: 8] = data[b*8 +: 8];
		end
		return res;
	endfunction : merge

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// the master holds address and data until ready, so both are read live
	always_comb begin
		wpage = s_axi_awaddr[7:4];
		wword = s_axi_awaddr[3:2];
		widx  = 2'(wpage - `MTS_WIN_FIRST);
		rpage = s_axi_araddr[7:4];
		rword = s_axi_araddr[3:2];
		ridx  = 2'(rpage - `MTS_WIN_FIRST);
		wr_ok = (s_axi_awaddr == `MTS_OFF_CTRL) || (s_axi_awaddr == `MTS_OFF_CMD)
			|| (s_axi_awaddr == `MTS_OFF_CLR)
			|| ((wpage >= `MTS_WIN_FIRST) && (wpage <= `MTS_WIN_LAST)
			&& (wword != 2'h3) && (s_axi_awaddr[1:0] == 2'h0));
		rd_ok = (s_axi_araddr[1:0] == 2'h0)
			&& ((rpage == 4'h0)
			|| ((rpage >= `MTS_WIN_FIRST) && (rpage <= `MTS_WIN_LAST) && (rword != 2'h3))
			|| (rpage == `MTS_ACC_PAGE));
	end

	// ----------------------------------------------------------------
	// write channel: take address and data together, then respond
	// ----------------------------------------------------------------
	always_comb begin
		wst_next     = wst_reg;
		awready_next = 1'b0;
		wready_next  = 1'b0;
		bvalid_next  = s_axi_bvalid;
		bresp_next   = s_axi_bresp;
		case (wst_reg)
			mts_pkg::MTS_BUS_IDLE: begin
				if (s_axi_awvalid && s_axi_wvalid) begin
					awready_next = 1'b1;
					wready_next  = 1'b1;
					wst_next     = mts_pkg::MTS_BUS_ACK;
				end
			end
			mts_pkg::MTS_BUS_ACK: begin
				bvalid_next = 1'b1;
				bresp_next  = wr_ok ? `MTS_RESP_OKAY : `MTS_RESP_SLVERR;
				wst_next    = mts_pkg::MTS_BUS_RESP;
			end
			mts_pkg::MTS_BUS_RESP: begin
				if (s_axi_bready) begin
					bvalid_next = 1'b0;
					wst_next    = mts_pkg::MTS_BUS_IDLE;
				end
			end
			default: begin
				bvalid_next = 1'b0;
				wst_next    = mts_pkg::MTS_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wst_reg       <= mts_pkg::MTS_BUS_IDLE;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `MTS_RESP_OKAY;
		end else begin
			wst_reg       <= wst_next;
			s_axi_awready <= awready_next;
			s_axi_wready  <= wready_next;
			s_axi_bvalid  <= bvalid_next;
			s_axi_bresp   <= bresp_next;
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	always_comb begin
		rst_next     = rst_reg;
		arready_next = 1'b0;
		rvalid_next  = s_axi_rvalid;
		rresp_next   = s_axi_rresp;
		rdata_next   = s_axi_rdata;
		case (rst_reg)
			mts_pkg::MTS_BUS_IDLE: begin
				if (s_axi_arvalid) begin
					arready_next = 1'b1;
					rst_next     = mts_pkg::MTS_BUS_ACK;
				end
			end
			mts_pkg::MTS_BUS_ACK: begin
				rvalid_next = 1'b1;
				rresp_next  = rd_ok ? `MTS_RESP_OKAY : `MTS_RESP_SLVERR;
				rdata_next  = `MTS_RST_WORD;
				if (s_axi_araddr == `MTS_OFF_CTRL)
					rdata_next = ctrl_reg;
				else if (s_axi_araddr == `MTS_OFF_CMD)
					rdata_next = cmd_reg;
				else if (s_axi_araddr == `MTS_OFF_STAT) begin
					rdata_next[`MTS_STAT_ACT]   = act_reg;
					rdata_next[`MTS_STAT_VALID] = win_valid;
					rdata_next[`MTS_STAT_CONFL] = confl_reg;
					rdata_next[`MTS_STAT_INVAL] = |(win_en & ~win_valid);
				end else if (rpage == `MTS_ACC_PAGE)
					rdata_next = acc[rword];
				else if (rd_ok && (rpage != 4'h0)) begin
					case (rword)
						`MTS_WIN_TIME: rdata_next = wt_reg[ridx];
						`MTS_WIN_DATE: rdata_next = wd_reg[ridx];
						default:       rdata_next = wc_reg[ridx];
					endcase
				end
				rst_next = mts_pkg::MTS_BUS_RESP;
			end
			mts_pkg::MTS_BUS_RESP: begin
				if (s_axi_rready) begin
					rvalid_next = 1'b0;
					rst_next    = mts_pkg::MTS_BUS_IDLE;
				end
			end
			default: begin
				rvalid_next = 1'b0;
				rst_next    = mts_pkg::MTS_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_reg       <= mts_pkg::MTS_BUS_IDLE;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= `MTS_RESP_OKAY;
			s_axi_rdata   <= `MTS_RST_WORD;
		end else begin
			rst_reg       <= rst_next;
			s_axi_arready <= arready_next;
			s_axi_rvalid  <= rvalid_next;
			s_axi_rresp   <= rresp_next;
			s_axi_rdata   <= rdata_next;
		end
	end

	// enable bits of all windows gathered into one vector
	for (genvar i = 0; i < NT; i++) begin : g_en
		assign win_en[i] = wc_reg[i][`MTS_CFG_EN];
	end

	// ----------------------------------------------------------------
	// configuration registers, written in the ack cycle
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_next = ctrl_reg;
		cmd_next  = cmd_reg;
		wt_next   = wt_reg;
		wd_next   = wd_reg;
		wc_next   = wc_reg;
		clr_next  = '0;
		if ((wst_reg == mts_pkg::MTS_BUS_ACK) && wr_ok) begin
			if (s_axi_awaddr == `MTS_OFF_CTRL)
				ctrl_next = merge(ctrl_reg, s_axi_wdata, s_axi_wstrb);
			else if (s_axi_awaddr == `MTS_OFF_CMD)
				cmd_next = merge(cmd_reg, s_axi_wdata, s_axi_wstrb);
			else if (s_axi_awaddr == `MTS_OFF_CLR) begin
				if (s_axi_wstrb[0])
					clr_next = s_axi_wdata[`MTS_CLR_BITS];
			end else begin
				case (wword)
					`MTS_WIN_TIME: wt_next[widx] = merge(wt_reg[widx], s_axi_wdata, s_axi_wstrb);
					`MTS_WIN_DATE: wd_next[widx] = merge(wd_reg[widx], s_axi_wdata, s_axi_wstrb);
					default:       wc_next[widx] = merge(wc_reg[widx], s_axi_wdata, s_axi_wstrb);
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= `MTS_RST_WORD;
			cmd_reg  <= `MTS_RST_WORD;
			wt_reg   <= '0;
			wd_reg   <= '0;
			wc_reg   <= '0;
			clr_reg  <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			cmd_reg  <= cmd_next;
			wt_reg   <= wt_next;
			wd_reg   <= wd_next;
			wc_reg   <= wc_next;
			clr_reg  <= clr_next;
		end
	end

	// ----------------------------------------------------------------
	// schedule windows
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NT; i++) begin : g_win
		mts_window u_win (
			.time_cfg (wt_reg[i]),
			.date_cfg (wd_reg[i]),
			.win_cfg  (wc_reg[i]),
			.now_min  (snap_min_reg),
			.now_mon  (snap_mon_reg),
			.now_day  (snap_day_reg),
			.now_wday (snap_wd_reg),
			.valid    (win_valid[i]),
			.hit      (win_hit[i])
		);
	end

	// ----------------------------------------------------------------
	// tariff candidates of each mode
	// ----------------------------------------------------------------
	// overlapping hits select nothing, so energy is never split or misfiled
	always_comb begin
		tod_tar = `MTS_TAR_NONE;
		hit_cnt = 3'h0;
		for (int i = 0; i < NT; i++) begin
			if (win_hit[i]) begin
				hit_cnt = hit_cnt + 3'h1;
				tod_tar = 3'(i + 1);
			end
		end
		if (hit_cnt > 3'h1)
			tod_tar = `MTS_TAR_NONE;
		if (ctrl_reg[`MTS_CTRL_DICFG])
			di_tar = {1'b0, din2, din1};
		else
			di_tar = {1'b0, din2, din1} + 3'h1;
		if (cmd_reg[`MTS_CMD_SEL] <= `MTS_TAR_MAX)
			cmd_tar = cmd_reg[`MTS_CMD_SEL];
		else
			cmd_tar = `MTS_TAR_NONE;
	end

	// ----------------------------------------------------------------
	// clock snapshot and active tariff
	// ----------------------------------------------------------------
	always_comb begin
		snap_min_next = snap_min_reg;
		snap_mon_next = snap_mon_reg;
		snap_day_next = snap_day_reg;
		snap_wd_next  = snap_wd_reg;
		snap_ok_next  = 1'b1;
		if (!snap_ok_reg || (rtc_min_of_day != snap_min_reg)) begin
			snap_min_next = rtc_min_of_day;
			snap_mon_next = rtc_month;
			snap_day_next = rtc_day;
			snap_wd_next  = rtc_wday;
		end
		case (mts_pkg::mts_mode_e'(ctrl_reg[`MTS_CTRL_MODE]))
			mts_pkg::MTS_MODE_CMD: act_next = cmd_tar;
			mts_pkg::MTS_MODE_TOD: act_next = tod_tar;
			mts_pkg::MTS_MODE_DI:  act_next = di_tar;
			default:               act_next = `MTS_TAR_NONE;
		endcase
		for (int i = 0; i < NT; i++)
			sel_next[i] = (act_next == 3'(i + 1));
		confl_next = (hit_cnt > 3'h1);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			snap_min_reg <= '0;
			snap_mon_reg <= '0;
			snap_day_reg <= '0;
			snap_wd_reg  <= '0;
			snap_ok_reg  <= 1'b0;
			act_reg      <= `MTS_TAR_NONE;
			tariff_sel   <= '0;
			confl_reg    <= 1'b0;
		end else begin
			snap_min_reg <= snap_min_next;
			snap_mon_reg <= snap_mon_next;
			snap_day_reg <= snap_day_next;
			snap_wd_reg  <= snap_wd_next;
			snap_ok_reg  <= snap_ok_next;
			act_reg      <= act_next;
			tariff_sel   <= sel_next;
			confl_reg    <= confl_next;
		end
	end

	assign tariff_code = act_reg;

	// ----------------------------------------------------------------
	// energy accumulators
	// ----------------------------------------------------------------
	mts_accum u_acc (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.add_vld (energy_vld && (act_reg != `MTS_TAR_NONE)),
		.add_sel (2'(act_reg - 3'h1)),
		.add_val (energy_inc),
		.clr     (clr_reg),
		.acc     (acc)
	);

endmodule : mts_selector

`default_nettype wire

// [rtl/mts_regs.svh]
// register map, field positions, reset values and limits of the tariff selector
`ifndef MTS_REGS_SVH
`define MTS_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MTS_OFF_CTRL    8'h00
`define MTS_OFF_CMD     8'h04
`define MTS_OFF_STAT    8'h08
`define MTS_OFF_CLR     8'h0C
// windows sit on pages 1..4 (addr[7:4]), word addr[3:2] inside a page
`define MTS_WIN_FIRST   4'h1
`define MTS_WIN_LAST    4'h4
`define MTS_WIN_TIME    2'h0
`define MTS_WIN_DATE    2'h1
`define MTS_WIN_CFG     2'h2
// accumulators on page 5, one word per tariff
`define MTS_ACC_PAGE    4'h5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MTS_CTRL_MODE   1:0
`define MTS_CTRL_DICFG  4
`define MTS_CMD_SEL     2:0
`define MTS_CLR_BITS    3:0
`define MTS_TIME_START  10:0
`define MTS_TIME_END    26:16
`define MTS_DATE_SMON   3:0
`define MTS_DATE_SDAY   12:8
`define MTS_DATE_EMON   19:16
`define MTS_DATE_EDAY   28:24
`define MTS_CFG_EN      0
`define MTS_CFG_DTYPE   7:4
`define MTS_STAT_ACT    2:0
`define MTS_STAT_VALID  7:4
`define MTS_STAT_CONFL  8
`define MTS_STAT_INVAL  9

// ----------------------------------------------------------------
// reset values, codes and limits
// ----------------------------------------------------------------
`define MTS_RST_WORD    32'h0000_0000
`define MTS_TAR_NONE    3'h0
`define MTS_TAR_MAX     3'h4
`define MTS_NUM_TAR     4
`define MTS_MIN_PER_DAY 11'h5A0
`define MTS_MON_MIN     4'h1
`define MTS_MON_MAX     4'hC
`define MTS_MON_FEB     4'h2
`define MTS_DAY_MIN     5'h01
`define MTS_DAY_MAX     5'h1F
`define MTS_DAY_FEB_MAX 5'h1D
`define MTS_WD_SAT      3'h5
`define MTS_WD_SUN      3'h6
`define MTS_RESP_OKAY   2'h0
`define MTS_RESP_SLVERR 2'h2

`endif

// [rtl/mts_pkg.sv]
// types shared by the tariff selector modules
package mts_pkg;

	// tariff source selected by software
	typedef enum logic [1:0] {
		MTS_MODE_CMD = 2'h0,
		MTS_MODE_TOD = 2'h1,
		MTS_MODE_DI  = 2'h2
	} mts_mode_e;

	// day type of a schedule window; named days follow monday onward
	typedef enum logic [3:0] {
		MTS_DT_EVERY   = 4'h0,
		MTS_DT_WEEKDAY = 4'h1,
		MTS_DT_WEEKEND = 4'h2,
		MTS_DT_MON     = 4'h3,
		MTS_DT_SUN     = 4'h9
	} mts_dtype_e;

	// bus channel handshake states, gray along idle-ack-resp
	typedef enum logic [1:0] {
		MTS_BUS_IDLE = 2'b00,
		MTS_BUS_ACK  = 2'b01,
		MTS_BUS_RESP = 2'b11
	} mts_bus_e;

	typedef logic [2:0] mts_tar_t;

endpackage : mts_pkg

// [rtl/mts_window.sv]
// one schedule window: validation of its settings and match against the clock
`timescale 1ns/100ps
`default_nettype none
`include "mts_regs.svh"

module mts_window (
	input  wire logic [31:0] time_cfg,
	input  wire logic [31:0] date_cfg,
	input  wire logic [31:0] win_cfg,
	input  wire logic [10:0] now_min,
	input  wire logic [3:0]  now_mon,
	input  wire logic [4:0]  now_day,
	input  wire logic [2:0]  now_wday,
	output logic             valid,
	output logic             hit
);

	logic [10:0] s_t, e_t;
	logic [3:0]  smon, emon, dt;
	logic [4:0]  sday, eday;
	logic [8:0]  s_d, e_d, n_d;
	logic        fmt_ok, day_ok, date_ok, time_ok, weekend;

	// ----------------------------------------------------------------
	// validation and matching
	// ----------------------------------------------------------------
	always_comb begin
		s_t  = time_cfg[`MTS_TIME_START];
		e_t  = time_cfg[`MTS_TIME_END];
		smon = date_cfg[`MTS_DATE_SMON];
		sday = date_cfg[`MTS_DATE_SDAY];
		emon = date_cfg[`MTS_DATE_EMON];
		eday = date_cfg[`MTS_DATE_EDAY];
		dt   = win_cfg[`MTS_CFG_DTYPE];
		// february may hold the 29th; it simply never matches in other years
		fmt_ok = (s_t < `MTS_MIN_PER_DAY) && (e_t < `MTS_MIN_PER_DAY)
			&& (smon >= `MTS_MON_MIN) && (smon <= `MTS_MON_MAX)
			&& (emon >= `MTS_MON_MIN) && (emon <= `MTS_MON_MAX)
			&& (sday >= `MTS_DAY_MIN) && (eday >= `MTS_DAY_MIN)
			&& !((smon == `MTS_MON_FEB) && (sday > `MTS_DAY_FEB_MAX))
			&& !((emon == `MTS_MON_FEB) && (eday > `MTS_DAY_FEB_MAX))
			&& (dt <= mts_pkg::MTS_DT_SUN);
		valid = win_cfg[`MTS_CFG_EN] && fmt_ok
			&& (s_t != e_t)
			&& ((s_t < e_t) || (dt == mts_pkg::MTS_DT_EVERY))
			&& !((smon == emon) && (sday >= eday));
		weekend = (now_wday == `MTS_WD_SAT) || (now_wday == `MTS_WD_SUN);
		case (dt)
			mts_pkg::MTS_DT_EVERY:   day_ok = 1'b1;
			mts_pkg::MTS_DT_WEEKDAY: day_ok = !weekend;
			mts_pkg::MTS_DT_WEEKEND: day_ok = weekend;
			default:                 day_ok = (dt == (4'(mts_pkg::MTS_DT_MON) + {1'b0, now_wday}));
		endcase
		// dates carry no year, so a window repeats every year
		s_d = {smon, sday};
		e_d = {emon, eday};
		n_d = {now_mon, now_day};
		if (s_d <= e_d)
			date_ok = (n_d >= s_d) && (n_d <= e_d);
		else
			date_ok = (n_d >= s_d) || (n_d <= e_d);
		// end minute is inclusive up to its last second; no daylight shift
		if (s_t < e_t)
			time_ok = (now_min >= s_t) && (now_min <= e_t);
		else
			time_ok = (now_min >= s_t) || (now_min <= e_t);
		hit = valid && day_ok && date_ok && time_ok;
	end

endmodule : mts_window

`default_nettype wire

// [rtl/mts_accum.sv]
// per-tariff energy accumulators
`timescale 1ns/100ps
`default_nettype none
`include "mts_regs.svh"

module mts_accum (
	input  wire logic                        ref_clk,
	input  wire logic                        nrst,
	input  wire logic                        add_vld,
	input  wire logic [1:0]                  add_sel,
	input  wire logic [15:0]                 add_val,
	input  wire logic [`MTS_NUM_TAR-1:0]     clr,
	output logic      [`MTS_NUM_TAR-1:0][31:0] acc
);

	logic [`MTS_NUM_TAR-1:0][31:0] acc_next;

	// ----------------------------------------------------------------
	// one accumulator per tariff
	// ----------------------------------------------------------------
	for (genvar i = 0; i < `MTS_NUM_TAR; i++) begin : g_acc
		// a clear that meets an add keeps the new energy
		always_comb begin
			acc_next[i] = acc[i];
			if (add_vld && (add_sel == 2'(i))) begin
				if (clr[i])
					acc_next[i] = {16'h0000, add_val};
				else
					acc_next[i] = acc[i] + {16'h0000, add_val};
			end else if (clr[i]) begin
				acc_next[i] = `MTS_RST_WORD;
			end
		end

		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst)
				acc[i] <= `MTS_RST_WORD;
			else
				acc[i] <= acc_next[i];
		end
	end

endmodule : mts_accum

`default_nettype wire

// [test/mts_selector_assertions.sv]
// port checker of the tariff selector
`timescale 1ns/100ps
`default_nettype none
module mts_selector_chk (
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        din1,
	input wire logic        din2,
	input wire logic [10:0] rtc_min_of_day,
	input wire logic [3:0]  rtc_month,
	input wire logic [4:0]  rtc_day,
	input wire logic [2:0]  rtc_wday,
	input wire logic [2:0]  tariff_code,
	input wire logic [3:0]  tariff_sel
);
	// ------
	// tariff and bus
	// ------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// no cause moved; three edges cover the two-stage schedule path
	sequence quiet_s;
		!s_axi_wready && $stable({din1, din2, rtc_min_of_day, rtc_month, rtc_day, rtc_wday});
	endsequence
	one_hot_a: assert property ($onehot0(tariff_sel))
		else $error("more than one tariff active");
	code_range_a: assert property (tariff_code <= 3'h4)
		else $error("tariff code out of range");
	sel_match_a: assert property (tariff_code != 3'h0 |-> tariff_sel[tariff_code - 3'h1])
		else $error("select disagrees with code");
	none_off_a: assert property ((tariff_code == 3'h0) == (tariff_sel == 4'h0))
		else $error("select active with no tariff");
	hold_code_a: assert property (quiet_s [*3] |=> $stable(tariff_code))
		else $error("tariff moved without cause");
	pair_a: assert property (s_axi_awready == s_axi_wready)
		else $error("address and data taken apart");
	wresp_a: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("write answer late");
	bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	cover property (tariff_code == 3'h4);
	cover property ($fell(tariff_sel[0]));
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : mts_selector_chk
bind mts_selector mts_selector_chk mts_selector_chk_i (.*);
`default_nettype wire

// [test/mts_host.sv]
// bus host model that reads and writes the selector registers
`timescale 1ns/100ps
`default_nettype none
module mts_host (
	input  wire logic        ref_clk,
	output logic      [7:0]  s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic      [31:0] s_axi_wdata,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	output logic      [7:0]  s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready,
	output logic             timed_out
);
	// ------
	// host requests
	// ------
	initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
	initial {s_axi_araddr, s_axi_arvalid, s_axi_rready, timed_out} = '0;
	// register write; bready comes late so the answer must stand
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (i = 0; i < 99; i++) begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_bvalid) s_axi_bready <= 1'h1;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
		if (i == 99) timed_out <= 1'h1;
	endtask : wr
	// read with rready up from the start
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (i = 0; i < 99; i++) begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		if (i == 99) timed_out <= 1'h1;
	endtask : rd
endmodule : mts_host
`default_nettype wire

// [test/testbench.sv]
// self-checking bench of the tariff selector
`timescale 1ns/100ps
`default_nettype none
`include "mts_regs.svh"
module testbench;
	logic        ref_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, din1, din2, energy_vld, timed_out;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, rtc_wday, tariff_code;
	logic [3:0]  s_axi_wstrb = 4'hF, rtc_month, tariff_sel;
	logic [4:0]  rtc_day;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [10:0] rtc_min_of_day;
	logic [15:0] energy_inc;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	int          fails, comparisons;
	mts_selector mts_selector_i (.*);
	mts_host     mts_host_i (.*);
	// ------
	// checking and verdict
	// ------
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// a host wait that ran out ends the run
	always @(posedge timed_out) begin
		fails++;
		print_verdict;
	end
	// command values 0 to 5, energy of k*16 booked under tariffs 1 to 4
	task automatic t_cmd;
		for (int k = 0; k < 6; k++) begin
			mts_host_i.wr(`MTS_OFF_CMD, k, r);
			repeat (2) @(posedge ref_clk);
			chk(tariff_code, (k < 5) ? k : 0);
			chk(tariff_sel, (k > 0 && k < 5) ? 4'h1 << (k - 1) : 0);
			energy_vld <= 1'h1;
			energy_inc <= 16'(k * 16);
			@(posedge ref_clk);
			energy_vld <= 1'h0;
		end
		for (int k = 0; k < 4; k++) begin
			mts_host_i.rd(8'h50 + 8'(4 * k), d, r);
			chk(d, (k + 1) * 16);
		end
		$display("command test done");
	endtask : t_cmd
	// both input configurations, all four codes
	task automatic t_di;
		for (int c = 0; c < 2; c++) begin
			mts_host_i.wr(`MTS_OFF_CTRL, 32'h2 | (c << 4), r);
			for (int k = 0; k < 4; k++) begin
				din2 <= k[1];
				din1 <= k[0];
				repeat (3) @(posedge ref_clk);
				chk(tariff_code, (c == 0) ? k + 1 : k);
			end
		end
		$display("input test done");
	endtask : t_di
	// every-day window 23:00-04:59; same window as weekday must be rejected as invalid
	task automatic t_tod;
		logic [10:0] m [3] = '{11'h59F, 11'h12B, 11'h12C};
		mts_host_i.wr(8'h10, 32'h012B_0564, r);
		mts_host_i.wr(8'h14, 32'h1F0C_0101, r);
		mts_host_i.wr(8'h18, 32'h0000_0001, r);
		mts_host_i.wr(8'h20, 32'h012B_0564, r);
		mts_host_i.wr(8'h24, 32'h1F0C_0101, r);
		mts_host_i.wr(8'h28, 32'h0000_0011, r);
		mts_host_i.wr(`MTS_OFF_CTRL, 32'h1, r);
		for (int k = 0; k < 3; k++) begin
			rtc_min_of_day <= m[k];
			repeat (3) @(posedge ref_clk);
			chk(tariff_code, (k < 2) ? 1 : 0);
		end
		mts_host_i.rd(`MTS_OFF_STAT, d, r);
		chk(d, 32'h0000_0210);
		mts_host_i.rd(8'h1C, d, r);
		chk(r, 2'h2);
		mts_host_i.wr(`MTS_OFF_STAT, 32'h0, r);
		chk(r, 2'h2);
		$display("schedule test done");
	endtask : t_tod
	// overlap, bad windows, year wrap, mode 3 and accumulator clear
	task automatic t_val;
		rtc_min_of_day <= 11'h000;
		mts_host_i.wr(8'h28, 32'h0000_0001, r);
		chk(tariff_code, 0);
		mts_host_i.rd(`MTS_OFF_STAT, d, r);
		chk(d, 32'h0000_0130);
		mts_host_i.wr(8'h24, 32'h0F06_0F06, r);
		chk(tariff_code, 1);
		mts_host_i.wr(8'h24, 32'h0F06_0107, r);
		mts_host_i.wr(8'h20, 32'h0564_0564, r);
		chk(tariff_code, 1);
		rtc_min_of_day <= 11'h258;
		mts_host_i.wr(8'h20, 32'h0563_012C, r);
		chk(tariff_code, 2);
		mts_host_i.wr(`MTS_OFF_CTRL, 32'h3, r);
		chk(tariff_code, 0);
		mts_host_i.wr(`MTS_OFF_CLR, 32'hF, r);
		mts_host_i.rd(8'h50, d, r);
		chk(d, 0);
		$display("validation test done");
	endtask : t_val
	initial begin
		nrst = 1'h0;
		{din1, din2, energy_vld, energy_inc} = '0;
		rtc_min_of_day = 11'h000;
		rtc_month = 4'h6;
		rtc_day = 5'h0F;
		rtc_wday = 3'h2;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'h1;
		t_cmd;
		t_di;
		t_tod;
		t_val;
		print_verdict;
	end
endmodule : testbench
`default_nettype wire
